// ---- scbs_status_regs.v ----
/*
 Sub-code and burst preamble status register bank of the receiver.
 Assumes a serial sub-code bit stream and a preamble word stream already
 recovered into core_clk_i, and a host port decoded to byte addresses.
*/
`timescale 1ns/1ps
`include "scbs_consts.vh"


module scbs_status_regs (
   input  wire        core_clk_i,
   input  wire        arst_n_i,
   // Receiver side
   input  wire        subcode_start_i,
   input  wire        subcode_bit_valid_i,
   input  wire        subcode_bit_i,
   input  wire        preamble_word_valid_i,
   input  wire [15:0] preamble_word_i,
   // Host side
   input  wire        host_wr_i,
   input  wire        host_rd_i,
   input  wire [6:0]  host_addr_i,
   input  wire [7:0]  host_wdata_i,
   output wire [7:0]  host_rdata_o,
   output wire        host_rvalid_o,
   output wire        host_hit_o,
   output wire [1:0]  page_sel_o,
   output wire        burst_seen_o,
   output wire        burst_error_o
);

   // ----------------------------------------
   // Page select
   // ----------------------------------------
   reg  [1:0] page_r;
   wire       page_hit;

   always @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         page_r <= `SCBS_PAGE_RESET;
      end else if (host_wr_i && host_addr_i == `SCBS_A_PAGE_SEL) begin
         page_r <= host_wdata_i[1:0];
      end
   end

   assign page_hit = (page_r == `SCBS_PAGE_STATUS);

   // ----------------------------------------
   // Sub-code shift and capture
   // ----------------------------------------
   // Bits shift in until a full block is seen, so a partial block
   // never disturbs the buffer the host is reading.
   reg [79:0] sub_shift_r;
   reg [79:0] sub_shift_nxt;
   reg [6:0]  bit_cnt_r;
   reg [6:0]  bit_cnt_nxt;
   reg        sub_load_r;
   reg        sub_load_nxt;

   always @* begin
      sub_shift_nxt = sub_shift_r;
      bit_cnt_nxt   = bit_cnt_r;
      sub_load_nxt  = 1'b0;
      if (subcode_bit_valid_i) begin
         if (subcode_start_i) begin
            sub_shift_nxt = {sub_shift_r[78:0], subcode_bit_i};
            // A start mid-block drops the partial block and restarts the count
            bit_cnt_nxt   = `SCBS_BIT_CNT_ONE;
         end else begin
            sub_shift_nxt = {sub_shift_r[78:0], subcode_bit_i};
            if (bit_cnt_r == `SCBS_BIT_CNT_LAST) begin
               bit_cnt_nxt  = `SCBS_BIT_CNT_ZERO;
               sub_load_nxt = 1'b1;
            end else begin
               bit_cnt_nxt = bit_cnt_r + 7'h01;
            end
         end
      end
   end

   always @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         sub_shift_r <= `SCBS_SUB_ZERO;
         bit_cnt_r   <= `SCBS_BIT_CNT_ZERO;
         sub_load_r  <= 1'b0;
      end else begin
         sub_shift_r <= sub_shift_nxt;
         bit_cnt_r   <= bit_cnt_nxt;
         sub_load_r  <= sub_load_nxt;
      end
   end

   // First received bit sits in bit 79 of the shifter, i.e. bit 7 of byte 0
   wire [79:0] sub_bytes;
   genvar gi;
   generate
      for (gi = 0; gi < `SCBS_SUBCODE_BYTES; gi = gi + 1) begin : g_sub
         scbs_byte_reg u_byte (
            .core_clk_i (core_clk_i),
            .arst_n_i   (arst_n_i),
            .load_i     (sub_load_r),
            .data_i     (sub_shift_r[79-8*gi -: 8]),
            .value_o    (sub_bytes[79-8*gi -: 8])
         );
      end
   endgenerate

   // ----------------------------------------
   // Burst preamble tracking
   // ----------------------------------------
   localparam [4:0] ST_HUNT  = 5'b00001;
   localparam [4:0] ST_SYNC2 = 5'b00010;
   localparam [4:0] ST_INFO  = 5'b00100;
   localparam [4:0] ST_LEN   = 5'b01000;

   reg [4:0]  state_r;
   reg [4:0]  state_nxt;
   reg [15:0] info_hold_r;
   reg [15:0] info_hold_nxt;
   reg        burst_load_r;
   reg        burst_load_nxt;
   reg [15:0] len_hold_r;
   reg [15:0] len_hold_nxt;
   reg        seen_r;

   always @* begin
      state_nxt      = state_r;
      info_hold_nxt  = info_hold_r;
      len_hold_nxt   = len_hold_r;
      burst_load_nxt = 1'b0;
      if (preamble_word_valid_i) begin
         case (state_r)
            ST_HUNT: begin
               if (preamble_word_i == `SCBS_SYNC_WORD_FIRST)
                  state_nxt = ST_SYNC2;
            end
            ST_SYNC2: begin
               if (preamble_word_i == `SCBS_SYNC_WORD_SECOND)
                  state_nxt = ST_INFO;
               else if (preamble_word_i == `SCBS_SYNC_WORD_FIRST)
                  state_nxt = ST_SYNC2;
               else
                  state_nxt = ST_HUNT;
            end
            ST_INFO: begin
               // Reserved bits forced low; all others pass as received
               info_hold_nxt = preamble_word_i & `SCBS_INFO_RSVD_MASK;
               state_nxt     = ST_LEN;
            end
            ST_LEN: begin
               len_hold_nxt   = preamble_word_i;
               burst_load_nxt = 1'b1;
               state_nxt      = ST_HUNT;
            end
            default: begin
               state_nxt = ST_HUNT;
            end
         endcase
      end
   end

   always @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         state_r      <= ST_HUNT;
         info_hold_r  <= `SCBS_WORD_ZERO;
         len_hold_r   <= `SCBS_WORD_ZERO;
         burst_load_r <= 1'b0;
         seen_r       <= 1'b0;
      end else begin
         state_r      <= state_nxt;
         info_hold_r  <= info_hold_nxt;
         len_hold_r   <= len_hold_nxt;
         burst_load_r <= burst_load_nxt;
         if (burst_load_r)
            seen_r <= 1'b1;
      end
   end

   // Info and length update together so the host never sees a mixed pair
   wire [31:0] burst_bytes;
   wire [31:0] burst_src;
   assign burst_src = {info_hold_r, len_hold_r};

   generate
      for (gi = 0; gi < 4; gi = gi + 1) begin : g_burst
         scbs_byte_reg u_byte (
            .core_clk_i (core_clk_i),
            .arst_n_i   (arst_n_i),
            .load_i     (burst_load_r),
            .data_i     (burst_src[31-8*gi -: 8]),
            .value_o    (burst_bytes[31-8*gi -: 8])
         );
      end
   endgenerate

   // ----------------------------------------
   // Named status bytes
   // ----------------------------------------
   // Each byte under its own name, so the read decode below reads as the map
   wire [7:0]  subcode_lead_byte;
   wire [7:0]  subcode_track;
   wire [7:0]  subcode_index;
   wire [7:0]  subcode_minutes;
   wire [7:0]  subcode_seconds;
   wire [7:0]  subcode_frame;
   wire [7:0]  subcode_zero;
   wire [7:0]  subcode_abs_minutes;
   wire [7:0]  subcode_abs_seconds;
   wire [7:0]  subcode_abs_frame;
   wire [7:0]  burst_type_high;
   wire [7:0]  burst_type_low;
   wire [7:0]  burst_len_high;
   wire [7:0]  burst_len_low;
   wire [15:0] burst_info_word;
   wire [15:0] burst_length_word;

   assign subcode_lead_byte   = sub_bytes[79:72];
   assign subcode_track       = sub_bytes[71:64];
   assign subcode_index       = sub_bytes[63:56];
   assign subcode_minutes     = sub_bytes[55:48];
   assign subcode_seconds     = sub_bytes[47:40];
   assign subcode_frame       = sub_bytes[39:32];
   assign subcode_zero        = sub_bytes[31:24];
   assign subcode_abs_minutes = sub_bytes[23:16];
   assign subcode_abs_seconds = sub_bytes[15:8];
   assign subcode_abs_frame   = sub_bytes[7:0];
   assign burst_info_word     = burst_bytes[31:16];
   assign burst_length_word   = burst_bytes[15:0];
   assign burst_type_high     = burst_info_word[15:8];
   assign burst_type_low      = burst_info_word[7:0];
   assign burst_len_high      = burst_length_word[15:8];
   assign burst_len_low       = burst_length_word[7:0];

   // ----------------------------------------
   // Host read path
   // ----------------------------------------
   // Reads mux a status byte into rdata_r one cycle later; no status register changes state on a read.
   reg [7:0] rdata_r;
   reg [7:0] rdata_nxt;
   reg       rvalid_r;
   reg       hit_nxt;
   reg       hit_r;

   always @* begin
      rdata_nxt = `SCBS_BYTE_ZERO;
      hit_nxt   = 1'b0;
      if (host_addr_i == `SCBS_A_PAGE_SEL) begin
         rdata_nxt = {`SCBS_PAGE_PAD, page_r};
         hit_nxt   = 1'b1;
      end else if (page_hit) begin
         case (host_addr_i)
            `SCBS_A_SUBCODE_FIRST: begin
               rdata_nxt = subcode_lead_byte;
               hit_nxt   = 1'b1;
            end
            `SCBS_A_SUB_TRACK: begin
               rdata_nxt = subcode_track;
               hit_nxt   = 1'b1;
            end
            `SCBS_A_SUB_INDEX: begin
               rdata_nxt = subcode_index;
               hit_nxt   = 1'b1;
            end
            `SCBS_A_SUB_MINUTES: begin
               rdata_nxt = subcode_minutes;
               hit_nxt   = 1'b1;
            end
            `SCBS_A_SUB_SECONDS: begin
               rdata_nxt = subcode_seconds;
               hit_nxt   = 1'b1;
            end
            `SCBS_A_SUB_FRAME: begin
               rdata_nxt = subcode_frame;
               hit_nxt   = 1'b1;
            end
            `SCBS_A_SUB_ZERO_BYTE: begin
               rdata_nxt = subcode_zero;
               hit_nxt   = 1'b1;
            end
            `SCBS_A_SUB_ABS_MIN: begin
               rdata_nxt = subcode_abs_minutes;
               hit_nxt   = 1'b1;
            end
            `SCBS_A_SUB_ABS_SEC: begin
               rdata_nxt = subcode_abs_seconds;
               hit_nxt   = 1'b1;
            end
            `SCBS_A_SUBCODE_LAST: begin
               rdata_nxt = subcode_abs_frame;
               hit_nxt   = 1'b1;
            end
            `SCBS_A_INFO_HIGH: begin
               rdata_nxt = burst_type_high;
               hit_nxt   = 1'b1;
            end
            `SCBS_A_INFO_LOW: begin
               rdata_nxt = burst_type_low;
               hit_nxt   = 1'b1;
            end
            `SCBS_A_LEN_HIGH: begin
               rdata_nxt = burst_len_high;
               hit_nxt   = 1'b1;
            end
            `SCBS_A_LEN_LOW: begin
               rdata_nxt = burst_len_low;
               hit_nxt   = 1'b1;
            end
            default: begin
               rdata_nxt = `SCBS_BYTE_ZERO;
            end
         endcase
      end
   end

   always @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         rdata_r  <= `SCBS_BYTE_ZERO;
         rvalid_r <= 1'b0;
         hit_r    <= 1'b0;
      end else begin
         rvalid_r <= host_rd_i;
         if (host_rd_i) begin
            rdata_r <= rdata_nxt;
            hit_r   <= hit_nxt;
         end
      end
   end

   assign host_rdata_o  = rdata_r;
   assign host_rvalid_o = rvalid_r;
   assign host_hit_o    = hit_r;
   assign page_sel_o    = page_r;
   assign burst_seen_o  = seen_r;
   assign burst_error_o = burst_info_word[`SCBS_INFO_ERR_BIT];

endmodule // scbs_status_regs

// ---- scbs_consts.vh ----
/*
 Constants for the sub-code and burst status register bank: register
 addresses, page select, burst sync words and field positions.
 Assumes inclusion by bare name from the design files.
*/
`ifndef SCBS_CONSTS_VH
`define SCBS_CONSTS_VH

// ----------------------------------------
// Register addresses, page 0, and page select on any page
// ----------------------------------------
`define SCBS_ADDR_W            7
`define SCBS_A_SUBCODE_FIRST   7'h1f
`define SCBS_A_SUB_TRACK       7'h20
`define SCBS_A_SUB_INDEX       7'h21
`define SCBS_A_SUB_MINUTES     7'h22
`define SCBS_A_SUB_SECONDS     7'h23
`define SCBS_A_SUB_FRAME       7'h24
`define SCBS_A_SUB_ZERO_BYTE   7'h25
`define SCBS_A_SUB_ABS_MIN     7'h26
`define SCBS_A_SUB_ABS_SEC     7'h27
`define SCBS_A_SUBCODE_LAST    7'h28
`define SCBS_A_INFO_HIGH       7'h29
`define SCBS_A_INFO_LOW        7'h2a
`define SCBS_A_LEN_HIGH        7'h2b
`define SCBS_A_LEN_LOW         7'h2c
`define SCBS_A_PAGE_SEL        7'h7f
`define SCBS_PAGE_W            2
`define SCBS_PAGE_STATUS       2'h0
`define SCBS_PAGE_RESET        2'h0
`define SCBS_PAGE_PAD          6'h00

// ----------------------------------------
// Buffer geometry
// ----------------------------------------
`define SCBS_SUBCODE_BITS      80
`define SCBS_SUBCODE_BYTES     10
`define SCBS_BIT_CNT_W         7
`define SCBS_BIT_CNT_ZERO      7'h00
`define SCBS_BIT_CNT_ONE       7'h01
`define SCBS_SUB_ZERO          80'h0
`define SCBS_BIT_CNT_LAST      7'h4f
`define SCBS_WORD_CNT_W        2

// ----------------------------------------
// Burst preamble
// ----------------------------------------
`define SCBS_SYNC_WORD_FIRST   16'hf872
`define SCBS_SYNC_WORD_SECOND  16'h4e1f
`define SCBS_INFO_RSVD_MASK    16'hff9f
`define SCBS_INFO_ERR_BIT      7
`define SCBS_BYTE_ZERO         8'h00
`define SCBS_WORD_ZERO         16'h0000

`endif

// ---- scbs_byte_reg.v ----
/*
 One read-only status byte register with load strobe.
 Assumes load strobe and data come from logic on the same clock.
*/
`timescale 1ns/1ps
`include "scbs_consts.vh"

module scbs_byte_reg (
   input  wire       core_clk_i,
   input  wire       arst_n_i,
   input  wire       load_i,
   input  wire [7:0] data_i,
   output wire [7:0] value_o
);
   reg [7:0] value_r;

   // Holds until the next decoded block; reads never touch it
   always @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         value_r <= `SCBS_BYTE_ZERO;
      end else if (load_i) begin
         value_r <= data_i;
      end
   end

   assign value_o = value_r;
endmodule // scbs_byte_reg

// ---- scbs_status_chk.sv ----
/*
 Checker for the status register bank host port.
 Assumes binding to scbs_status_regs; sees only its ports.
*/
`timescale 1ns/1ps
module scbs_status_chk (
   input wire logic       core_clk_i,
   input wire logic       arst_n_i,
   input wire logic       host_wr_i,
   input wire logic       host_rd_i,
   input wire logic [6:0] host_addr_i,
   input wire logic [7:0] host_wdata_i,
   input wire logic [7:0] host_rdata_o,
   input wire logic       host_rvalid_o,
   input wire logic       host_hit_o,
   input wire logic [1:0] page_sel_o,
   input wire logic       burst_error_o
);
   // ----------------------------------------
   // Host port properties
   // ----------------------------------------
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (!arst_n_i);
   a_rd_answer: assert property (1 |=> host_rvalid_o == $past(host_rd_i))
      else $error("read answer timing wrong");
   a_rdata_hold: assert property (!host_rvalid_o |-> $stable(host_rdata_o))
      else $error("read data moved without a read");
   a_map_hit: assert property (
      host_rd_i && page_sel_o == 2'h0 && host_addr_i >= 7'h1f && host_addr_i <= 7'h2c
      |=> host_hit_o)
      else $error("mapped read missed");
   a_off_page: assert property (
      host_rd_i && page_sel_o != 2'h0 && host_addr_i != 7'h7f
      |=> !host_hit_o && host_rdata_o == 8'h00)
      else $error("status answered off page 0");
   a_page_write: assert property (
      host_wr_i && host_addr_i == 7'h7f
      |=> {6'h00, page_sel_o} == ($past(host_wdata_i) & 8'h03))
      else $error("page write not taken");
   a_page_keep: assert property (
      !(host_wr_i && host_addr_i == 7'h7f) |=> $stable(page_sel_o))
      else $error("page changed without write");
   a_page_read: assert property (
      host_rd_i && host_addr_i == 7'h7f |=> host_rdata_o == {6'h00, $past(page_sel_o)})
      else $error("page read wrong");
   a_info_zero: assert property (
      host_rvalid_o && host_hit_o && $past(host_addr_i) == 7'h2a |-> host_rdata_o[6:5] == 2'h0)
      else $error("info bits 6 and 5 not zero");
   a_err_flag: assert property (
      host_rvalid_o && host_hit_o && $past(host_addr_i) == 7'h2a
      |-> host_rdata_o[7] == $past(burst_error_o))
      else $error("error flag output disagrees");
endmodule // scbs_status_chk
bind scbs_status_regs scbs_status_chk scbs_status_chk_inst (.*);

// ---- scbs_host_model.sv ----
/*
 Host controller model: byte reads and writes on the host port.
 Assumes the bench clock; answer comes one cycle after a read.
*/
`timescale 1ns/1ps
module scbs_host_model (
   input  wire logic       core_clk_i,
   input  wire logic [7:0] rdata_i,
   input  wire logic       rvalid_i,
   input  wire logic       hit_i,
   output logic            wr_o,
   output logic            rd_o,
   output logic [6:0]      addr_o,
   output logic [7:0]      wdata_o
);
   // ----------------------------------------
   // Host cycles
   // ----------------------------------------
   initial begin
      wr_o = 1'b0;
      rd_o = 1'b0;
      addr_o = 7'h00;
      wdata_o = 8'h00;
   end
   task automatic rd(input logic [6:0] a, output logic [7:0] d, output logic h, v);
      @(posedge core_clk_i);
      rd_o <= 1'b1;
      addr_o <= a;
      @(posedge core_clk_i);
      rd_o <= 1'b0;
      addr_o <= ~a;  // Released address shows junk, not a stale value
      #1;
      d = rdata_i;
      h = hit_i;
      v = rvalid_i;
   endtask
   // Page changes go through 0x7f, reachable on any page
   task automatic wr(input logic [6:0] a, input logic [7:0] d);
      @(posedge core_clk_i);
      wr_o <= 1'b1;
      addr_o <= a;
      wdata_o <= d;
      @(posedge core_clk_i);
      wr_o <= 1'b0;
      wdata_o <= ~d;
   endtask
endmodule // scbs_host_model

// ---- testbench.sv ----
/*
 Self-checking bench for the status register bank, with a reference model.
 Assumes the design files and host model are compiled alongside.
*/
`timescale 1ns/1ps
module testbench;
   logic        core_clk_i = 1'b0;
   logic        arst_n_i = 1'b0;
   logic        sc_start = 1'b0;
   logic        sc_valid = 1'b0;
   logic        sc_bit = 1'b0;
   logic        pw_valid = 1'b0;
   logic [15:0] pw = 16'h0000;
   logic        h_wr, h_rd, rv, hit, seen, err;
   logic [6:0]  h_addr;
   logic [7:0]  h_wdata, rdata;
   logic [1:0]  page;
   logic [7:0]  exp [0:127];
   logic [1:0]  pg = 2'h0;
   int          error_cnt = 0;
   int          n_compared = 0;
   int unsigned seed = 95;
   always #5 core_clk_i = ~core_clk_i;
   scbs_status_regs scbs_status_regs_inst (.core_clk_i(core_clk_i), .arst_n_i(arst_n_i),
      .subcode_start_i(sc_start), .subcode_bit_valid_i(sc_valid), .subcode_bit_i(sc_bit),
      .preamble_word_valid_i(pw_valid), .preamble_word_i(pw), .host_wr_i(h_wr),
      .host_rd_i(h_rd), .host_addr_i(h_addr), .host_wdata_i(h_wdata), .host_rdata_o(rdata),
      .host_rvalid_o(rv), .host_hit_o(hit), .page_sel_o(page), .burst_seen_o(seen),
      .burst_error_o(err));
   scbs_host_model scbs_host_model_inst (.core_clk_i(core_clk_i), .rdata_i(rdata),
      .rvalid_i(rv), .hit_i(hit), .wr_o(h_wr), .rd_o(h_rd), .addr_o(h_addr), .wdata_o(h_wdata));
   // ----------------------------------------
   // Model and checks
   // ----------------------------------------
   function automatic logic [31:0] nx();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   task automatic chk(input string n, input logic [15:0] e, g);
      n_compared++;
      if (g !== e) begin
         $display("unexpected %s expected %h seen %h", n, e, g);
         error_cnt++;
      end
   endtask
   task automatic rchk(input logic [6:0] a);
      logic [7:0]  d;
      logic        h, v, m;
      logic [15:0] e;
      scbs_host_model_inst.rd(a, d, h, v);
      m = (pg == 2'h0) && (a >= 7'h1f) && (a <= 7'h2c);
      e = (a == 7'h7f) ? {14'h0000, pg} : (m ? {8'h00, exp[a]} : 16'h0000);
      chk("rvalid", 16'h0001, {15'h0000, v});
      chk("hit", {15'h0000, m || a == 7'h7f}, {15'h0000, h});
      chk("rdata", e, {8'h00, d});
   endtask
   // Upper write bits carry junk on purpose; only the page field may stick
   task automatic pset(input logic [1:0] p);
      scbs_host_model_inst.wr(7'h7f, {6'h15, p});
      pg = p;
      #1;
      chk("page", {14'h0000, p}, {14'h0000, page});
   endtask
   // Partial blocks never reach the registers, so commit only a full one
   task automatic sub(input int n);
      logic [79:0] q;
      logic [31:0] r;
      for (int i = 0; i < n; i++) begin
         r = nx();
         q[i] = r[0];
         @(posedge core_clk_i);
         sc_valid <= 1'b1;
         sc_start <= (i == 0);
         sc_bit <= r[0];
      end
      @(posedge core_clk_i);
      sc_valid <= 1'b0;
      sc_start <= 1'b0;
      sc_bit <= ~sc_bit;
      repeat (2) @(posedge core_clk_i);
      if (n == 80) for (int i = 0; i < 80; i++) exp[7'h1f + i / 8][7 - i % 8] = q[i];
   endtask
   task automatic burst(input logic [15:0] s2, info, len);
      logic [15:0] w [4];
      w = '{16'hf872, s2, info, len};
      for (int k = 0; k < 4; k++) begin
         @(posedge core_clk_i);
         pw_valid <= 1'b1;
         pw <= w[k];
      end
      @(posedge core_clk_i);
      pw_valid <= 1'b0;
      pw <= ~len;
      repeat (2) @(posedge core_clk_i);
      #1;
      if (s2 == 16'h4e1f) begin
         info = info & 16'hff9f;
         {exp[7'h29], exp[7'h2a], exp[7'h2b], exp[7'h2c]} = {info, len};
         chk("seen", 16'h0001, {15'h0000, seen});
         chk("error", {15'h0000, info[7]}, {15'h0000, err});
      end
      for (int a = 8'h29; a <= 8'h2c; a++) rchk(a[6:0]);
   endtask
   task automatic results();
      $display("compared %0d mismatches %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   initial begin
      logic [31:0] r;
      for (int i = 0; i < 128; i++) exp[i] = 8'h00;
      repeat (20) @(posedge core_clk_i);
      arst_n_i <= 1'b1;
      @(posedge core_clk_i);
      #1;
      chk("seen", 16'h0000, {15'h0000, seen});
      chk("page", 16'h0000, {14'h0000, page});
      for (int a = 8'h1f; a <= 8'h2c; a++) rchk(a[6:0]);
      rchk(7'h10);
      sub(30);
      for (int a = 8'h1f; a <= 8'h28; a++) rchk(a[6:0]);
      sub(80);
      scbs_host_model_inst.wr(7'h20, 8'hff);
      for (int a = 8'h1f; a <= 8'h28; a++) repeat (2) rchk(a[6:0]);
      for (int t = 0; t < 32; t++) begin
         r = nx();
         burst(16'h4e1f, {r[15:5], t[4:0]}, r[31:16]);
      end
      burst(16'h1234, 16'h0103, 16'h0100);
      pset(2'h1);
      rchk(7'h29);
      rchk(7'h7f);
      pset(2'h3);
      rchk(7'h1f);
      pset(2'h0);
      rchk(7'h2a);
      results();
   end
   initial begin
      repeat (100000) @(posedge core_clk_i);
      error_cnt++;
      results();
   end
endmodule // testbench
